// ==== design/fpes_bus_cycle.sv ====
// one timed read or write cycle on the flash pins
// assumes requests arrive only while the previous cycle has finished
`timescale 1ns/1ps
module fpes_bus_cycle
    import fpes_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // cycle request and answer
    input  wire logic              req,
    input  wire logic              req_wr,
    input  wire logic              req_ce,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_data,
    output logic                   done,
    output logic [DATA_W-1:0]      rdata,
    // flash pins
    output logic [ADDR_W-1:0]      fl_addr,
    output logic [DATA_W-1:0]      fl_dq_o,
    output logic                   fl_dq_drive_n,
    input  wire logic [DATA_W-1:0] fl_dq_i,
    output logic                   fl_ce_n,
    output logic                   fl_we_n,
    output logic                   fl_oe_n
);

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_PULSE, BC_HOLD} fpes_bc_e;
    typedef struct packed {
        fpes_bc_e          st;
        logic [CNT_W-1:0]  cnt;
        logic              wr;
        logic              ce_mode;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_o;
        logic              drive_n;
        logic              ce_n;
        logic              we_n;
        logic              oe_n;
        logic              done;
        logic [DATA_W-1:0] rdata;
    } fpes_bc_s;

    fpes_bc_s s;
    fpes_bc_s next_s;

    // sequencing of strobes; ce_mode picks chip select as the delimiting strobe
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        case (s.st)
            BC_IDLE: begin
                if (req) begin
                    next_s.st      = BC_SETUP;
                    next_s.wr      = req_wr;
                    next_s.ce_mode = req_ce;
                    next_s.addr    = req_addr;
                    next_s.dq_o    = req_data;
                    next_s.drive_n = !req_wr;
                    // the strobe that does not delimit the cycle settles first
                    next_s.ce_n    = req_ce;
                    next_s.we_n    = !(req_wr && req_ce);
                    next_s.oe_n    = !(!req_wr && req_ce);
                end
            end
            BC_SETUP: begin
                next_s.st  = BC_PULSE;
                next_s.cnt = s.wr ? CNT_W'(WP_CYC - 1) : CNT_W'(ACC_CYC - 1);
                if (s.ce_mode) begin
                    next_s.ce_n = 1'b0;
                end else if (s.wr) begin
                    next_s.we_n = 1'b0;
                end else begin
                    next_s.oe_n = 1'b0;
                end
            end
            BC_PULSE: begin
                if (s.cnt == '0) begin
                    next_s.st  = BC_HOLD;
                    next_s.cnt = s.wr ? CNT_W'(WH_CYC - 1) : CNT_W'(OEH_CYC - 1);
                    if (s.ce_mode) begin
                        next_s.ce_n = 1'b1;
                    end else if (s.wr) begin
                        next_s.we_n = 1'b1;
                    end else begin
                        next_s.oe_n = 1'b1;
                    end
                    if (!s.wr) begin
                        next_s.rdata = fl_dq_i;  // sampled a full access time in
                    end
                end else begin
                    next_s.cnt = CNT_W'(s.cnt - 1'b1);
                end
            end
            default: begin
                if (s.cnt == '0) begin
                    next_s.st      = BC_IDLE;
                    next_s.done    = 1'b1;
                    next_s.ce_n    = 1'b1;
                    next_s.we_n    = 1'b1;
                    next_s.oe_n    = 1'b1;
                    next_s.drive_n = 1'b1;
                end else begin
                    next_s.cnt = CNT_W'(s.cnt - 1'b1);
                end
            end
        endcase
    end

    // state register; all strobes idle high after reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s         <= '0;
            s.st      <= BC_IDLE;
            s.drive_n <= 1'b1;
            s.ce_n    <= 1'b1;
            s.we_n    <= 1'b1;
            s.oe_n    <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // pins and answer straight from flops
    assign done          = s.done;
    assign rdata         = s.rdata;
    assign fl_addr       = s.addr;
    assign fl_dq_o       = s.dq_o;
    assign fl_dq_drive_n = s.drive_n;
    assign fl_ce_n       = s.ce_n;
    assign fl_we_n       = s.we_n;
    assign fl_oe_n       = s.oe_n;

    // ************************************************************
    // checks
    // ************************************************************
    // ce strobed write
    a_ce_write_strobe: assert property (
        @(posedge clk_sys) disable iff (rst)
        ($fell(fl_ce_n) && !fl_we_n) |->
            (!fl_ce_n && !fl_we_n) [*7] ##1 (fl_ce_n && !fl_we_n))
        else $error("chip select write pulse malformed");

    a_read_strobe_edge: assert property (
        @(posedge clk_sys) disable iff (rst)
        (($fell(fl_oe_n) && !fl_ce_n) || ($fell(fl_ce_n) && !fl_oe_n)) |->
            ##17 (!fl_ce_n && !fl_oe_n) ##1 (fl_ce_n || fl_oe_n))
        else $error("status read strobe not pulsed");

    a_no_bus_fight: assert property (
        @(posedge clk_sys) disable iff (rst)
        !fl_oe_n |-> fl_dq_drive_n)
        else $error("data driven while flash outputs enabled");

endmodule

// ==== design/fpes_flash_ctrl.sv ====
// host controller issuing program and erase sequences to a parallel flash
// and polling its status bits until completion or timeout
// assumes the flash pins are synchronous to clk_sys and one flash on the bus
`timescale 1ns/1ps

// Functional notes
// - status reads strobed by output or chip
// - program command is two or four writes
// - toggle any address, poll bit valid address
// - chip select may delimit write cycles
// - sector address on last erase write
module fpes_flash_ctrl
    import fpes_pkg::*;
#(
    parameter logic [TMO_W-1:0]  PROG_TMO      = TMO_W'(PROG_TMO_CYC),
    parameter logic [TMO_W-1:0]  SECT_TMO      = TMO_W'(SECT_TMO_CYC),
    parameter logic [TMO_W-1:0]  CHIP_TMO      = TMO_W'(CHIP_TMO_CYC),
    parameter logic [ADDR_W-1:0] UNLOCK_ADDR1  = 17'h0_0555,
    parameter logic [ADDR_W-1:0] UNLOCK_ADDR2  = 17'h0_02aa,
    parameter logic [DATA_W-1:0] CMD_UNLOCK1   = 8'haa,
    parameter logic [DATA_W-1:0] CMD_UNLOCK2   = 8'h55,
    parameter logic [DATA_W-1:0] CMD_PROG      = 8'ha0,
    parameter logic [DATA_W-1:0] CMD_ERASE     = 8'h80,
    parameter logic [DATA_W-1:0] CMD_SECT      = 8'h30,
    parameter logic [DATA_W-1:0] CMD_CHIP      = 8'h10,
    parameter logic [DATA_W-1:0] CMD_BYP_ENTER = 8'h20,
    parameter logic [DATA_W-1:0] CMD_BYP_EXIT1 = 8'h90,
    parameter logic [DATA_W-1:0] CMD_BYP_EXIT2 = 8'h00
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // user command
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire fpes_op_e          cmd_op,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [DATA_W-1:0] cmd_data,
    input  wire logic              cmd_bypass,
    input  wire logic              cmd_ce_write,
    input  wire logic              cmd_poll_toggle,
    input  wire logic              cmd_poll_by_ce,
    // result
    output logic                   rsp_valid,
    output logic                   rsp_timeout,
    output logic [DATA_W-1:0]      rsp_data,
    // flash pins
    output logic [ADDR_W-1:0]      fl_addr,
    output logic [DATA_W-1:0]      fl_dq_o,
    output logic                   fl_dq_drive_n,
    input  wire logic [DATA_W-1:0] fl_dq_i,
    output logic                   fl_ce_n,
    output logic                   fl_we_n,
    output logic                   fl_oe_n
);

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [2:0] {
        M_IDLE, M_WRITE, M_WAIT_W, M_POLL, M_WAIT_P, M_FINAL, M_WAIT_F
    } fpes_main_e;

    typedef struct packed {
        fpes_main_e        st;
        fpes_op_e          op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              byp;
        logic              ce_wr;
        logic              tog;
        logic              by_ce;
        logic [STEP_W-1:0] step;
        logic              have_prev;
        logic              prev_tog;
        logic [TMO_W-1:0]  tmo;
        logic              rsp_valid;
        logic              rsp_timeout;
        logic [DATA_W-1:0] rsp_data;
    } fpes_main_s;

    fpes_main_s s;
    fpes_main_s next_s;

    logic              req;
    logic              req_wr;
    logic              req_ce;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_data;
    logic              bus_done;
    logic [DATA_W-1:0] bus_rdata;
    logic [TMO_W-1:0]  limit;
    logic              tmo_over;
    logic [STEP_W-1:0] last;
    logic              expect_bit;
    logic              complete;

    // ************************************************************
    // command sequence tables
    // ************************************************************
    // address and data of one write of the sequence
    function automatic logic [ADDR_W+DATA_W-1:0] step_word(
        input fpes_op_e          op,
        input logic [STEP_W-1:0] step,
        input logic              byp,
        input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d
    );
        logic [ADDR_W+DATA_W-1:0] w;
        w = {a, d};
        case (step)
            3'h0: w = {UNLOCK_ADDR1, CMD_UNLOCK1};
            3'h1: w = {UNLOCK_ADDR2, CMD_UNLOCK2};
            3'h2: w = {UNLOCK_ADDR1, (op == OP_PROG) ? CMD_PROG :
                       (op == OP_BYP_ENTER) ? CMD_BYP_ENTER : CMD_ERASE};
            3'h3: w = (op == OP_PROG) ? {a, d} : {UNLOCK_ADDR1, CMD_UNLOCK1};
            3'h4: w = {UNLOCK_ADDR2, CMD_UNLOCK2};
            default: w = (op == OP_SECT_ERASE) ? {a, CMD_SECT} : {UNLOCK_ADDR1, CMD_CHIP};
        endcase
        if (op == OP_PROG && byp) begin
            w = (step == '0) ? {a, CMD_PROG} : {a, d};
        end
        if (op == OP_BYP_EXIT) begin
            w = {a, (step == '0) ? CMD_BYP_EXIT1 : CMD_BYP_EXIT2};
        end
        return w;
    endfunction

    // index of the final write for each operation
    always_comb begin
        case (s.op)
            OP_PROG:       last = s.byp ? LAST_PROG_SHORT : LAST_PROG_LONG;
            OP_SECT_ERASE: last = LAST_ERASE;
            OP_CHIP_ERASE: last = LAST_ERASE;
            OP_BYP_ENTER:  last = LAST_BYP_ENTER;
            OP_BYP_EXIT:   last = LAST_BYP_EXIT;
            default:       last = LAST_NONE;
        endcase
    end

    always_comb begin
        if (s.op == OP_PROG) begin
            limit = PROG_TMO;
        end else if (s.op == OP_SECT_ERASE) begin
            limit = SECT_TMO;  // doubled since zero preprogramming is extra
        end else begin
            limit = CHIP_TMO;  // no maximum exists, so a wide margin on typical
        end
    end
    assign tmo_over = (s.tmo >= limit);

    assign expect_bit = (s.op == OP_PROG) ? s.data[POLL_BIT] : ERASED_BYTE[POLL_BIT];
    assign complete = s.tog ? (s.have_prev && (bus_rdata[TOGGLE_BIT] == s.prev_tog))
                            : (bus_rdata[POLL_BIT] == expect_bit);

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        next_s = s;
        next_s.rsp_valid   = 1'b0;
        next_s.rsp_timeout = 1'b0;
        req      = 1'b0;
        req_wr   = 1'b0;
        req_ce   = s.by_ce;
        req_addr = s.addr;
        req_data = s.data;
        if (s.st == M_POLL || s.st == M_WAIT_P) begin
            next_s.tmo = TMO_W'(s.tmo + 1'b1);
        end
        case (s.st)
            M_IDLE: begin
                if (cmd_valid) begin
                    next_s.op    = cmd_op;
                    next_s.addr  = cmd_addr;
                    next_s.data  = cmd_data;
                    next_s.byp   = cmd_bypass;
                    next_s.ce_wr = cmd_ce_write;
                    next_s.tog   = cmd_poll_toggle;
                    next_s.by_ce = cmd_poll_by_ce;
                    next_s.step  = '0;
                    next_s.st    = (cmd_op == OP_READ) ? M_FINAL : M_WRITE;
                end
            end
            M_WRITE: begin
                req    = 1'b1;
                req_wr = 1'b1;
                req_ce = s.ce_wr;
                {req_addr, req_data} = step_word(s.op, s.step, s.byp, s.addr, s.data);
                next_s.st = M_WAIT_W;
            end
            M_WAIT_W: begin
                if (bus_done) begin
                    if (s.step != last) begin
                        next_s.step = STEP_W'(s.step + 1'b1);
                        next_s.st   = M_WRITE;
                    end else if (s.op == OP_PROG || s.op == OP_SECT_ERASE ||
                                 s.op == OP_CHIP_ERASE) begin
                        next_s.st        = M_POLL;
                        next_s.tmo       = '0;
                        next_s.have_prev = 1'b0;
                    end else begin
                        next_s.st        = M_IDLE;
                        next_s.rsp_valid = 1'b1;
                    end
                end
            end
            M_POLL: begin
                req       = 1'b1;
                next_s.st = M_WAIT_P;
            end
            M_WAIT_P: begin
                if (bus_done) begin
                    next_s.prev_tog  = bus_rdata[TOGGLE_BIT];
                    next_s.have_prev = 1'b1;
                    if (complete) begin
                        next_s.st = M_FINAL;
                    end else if (tmo_over) begin
                        next_s.st          = M_IDLE;
                        next_s.rsp_valid   = 1'b1;
                        next_s.rsp_timeout = 1'b1;
                        next_s.rsp_data    = bus_rdata;
                    end else begin
                        next_s.st = M_POLL;
                    end
                end
            end
            M_FINAL: begin
                req       = 1'b1;
                next_s.st = M_WAIT_F;
            end
            default: begin
                if (bus_done) begin
                    next_s.st        = M_IDLE;
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_data  = bus_rdata;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s    <= '0;
            s.st <= M_IDLE;
            s.op <= OP_READ;
        end else begin
            s <= next_s;
        end
    end

    assign cmd_ready   = (s.st == M_IDLE);
    assign rsp_valid   = s.rsp_valid;
    assign rsp_timeout = s.rsp_timeout;
    assign rsp_data    = s.rsp_data;

    // ************************************************************
    // pin timing engine
    // ************************************************************
    fpes_bus_cycle u_cycle (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .req           (req),
        .req_wr        (req_wr),
        .req_ce        (req_ce),
        .req_addr      (req_addr),
        .req_data      (req_data),
        .done          (bus_done),
        .rdata         (bus_rdata),
        .fl_addr       (fl_addr),
        .fl_dq_o       (fl_dq_o),
        .fl_dq_drive_n (fl_dq_drive_n),
        .fl_dq_i       (fl_dq_i),
        .fl_ce_n       (fl_ce_n),
        .fl_we_n       (fl_we_n),
        .fl_oe_n       (fl_oe_n)
    );

    // ************************************************************
    // checks
    // ************************************************************
    // program write count
    a_prog_seq_len: assert property (
        @(posedge clk_sys) disable iff (rst)
        (s.st == M_POLL && $past(s.st) == M_WAIT_W && s.op == OP_PROG) |->
            ($past(s.step) == (s.byp ? LAST_PROG_SHORT : LAST_PROG_LONG)))
        else $error("program sequence has wrong write count");

    a_sector_addr_last: assert property (
        @(posedge clk_sys) disable iff (rst)
        (req && req_wr && s.op == OP_SECT_ERASE && s.step == LAST_ERASE) |->
            (req_addr == s.addr) ##2 (fl_addr == s.addr))
        else $error("sector address missing on final erase write");

    a_poll_valid_addr: assert property (
        @(posedge clk_sys) disable iff (rst)
        (s.st == M_POLL && !s.tog) |-> ##1 (req_addr == s.addr) ##1 (fl_addr == s.addr))
        else $error("data poll read at wrong address");

    a_timeout_cause: assert property (
        @(posedge clk_sys) disable iff (rst)
        (rsp_valid && rsp_timeout) |-> $past(tmo_over))
        else $error("timeout reported before limit");

    a_cmd_accept_once: assert property (
        @(posedge clk_sys) disable iff (rst)
        (cmd_valid && cmd_ready) |=> !cmd_ready [*2])
        else $error("second command taken while busy");

endmodule

// ==== design/fpes_pkg.sv ====
// constants and types shared by the flash host controller files
// assumes a 200 MHz system clock and a byte-wide parallel flash
package fpes_pkg;

    // ************************************************************
    // bus widths and clock
    // ************************************************************
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int CLK_NS = 5;
    localparam int CNT_W  = 8;
    localparam int TMO_W  = 36;
    localparam int STEP_W = 3;

    // ************************************************************
    // bus cycle timing, slowest speed grade so every part works
    // ************************************************************
    localparam int T_WP_NS  = 35;
    localparam int T_WC_NS  = 90;
    localparam int T_ACC_NS = 90;
    localparam int T_OEH_NS = 10;
    localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WC_CYC   = (T_WC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WH_CYC   = WC_CYC - WP_CYC;  // also covers pulse high time
    localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int OEH_CYC  = (T_OEH_NS + CLK_NS - 1) / CLK_NS;

    // ************************************************************
    // embedded algorithm limits
    // ************************************************************
    localparam longint NS_PER_US      = 1000;
    localparam longint NS_PER_S       = 1000000000;
    localparam longint T_PROG_MAX_US  = 300;
    localparam longint T_SECT_MAX_S   = 15;
    localparam longint T_CHIP_TYP_S   = 6;
    localparam longint PREPROG_FACTOR = 2;
    localparam longint CHIP_MARGIN    = 10;
    localparam longint PROG_TMO_CYC   = T_PROG_MAX_US * NS_PER_US / CLK_NS;
    localparam longint SECT_TMO_CYC   = T_SECT_MAX_S * NS_PER_S / CLK_NS * PREPROG_FACTOR;
    localparam longint CHIP_TMO_CYC   = T_CHIP_TYP_S * NS_PER_S / CLK_NS * CHIP_MARGIN;

    // ************************************************************
    // status bits and command sequence shape
    // ************************************************************
    localparam int POLL_BIT   = 7;
    localparam int TOGGLE_BIT = 6;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
    localparam logic [STEP_W-1:0] LAST_PROG_LONG  = 3'h3;
    localparam logic [STEP_W-1:0] LAST_PROG_SHORT = 3'h1;
    localparam logic [STEP_W-1:0] LAST_ERASE      = 3'h5;
    localparam logic [STEP_W-1:0] LAST_BYP_ENTER  = 3'h2;
    localparam logic [STEP_W-1:0] LAST_BYP_EXIT   = 3'h1;
    localparam logic [STEP_W-1:0] LAST_NONE       = 3'h0;

    typedef enum logic [2:0] {
        OP_PROG,
        OP_SECT_ERASE,
        OP_CHIP_ERASE,
        OP_READ,
        OP_BYP_ENTER,
        OP_BYP_EXIT
    } fpes_op_e;

endpackage

// ==== test/fpes_flash_model.sv ====
// behavioural byte-wide flash that answers the host controller's pins
// assumes pins change just after clk_sys edges; stuck keeps it busy
`timescale 1ns/1ps
module fpes_flash_model
    import fpes_pkg::*;
(
    // clock and test knob
    input  wire logic              clk_sys,
    input  wire logic              stuck,
    // flash pins
    input  wire logic [ADDR_W-1:0] fl_addr,
    input  wire logic [DATA_W-1:0] fl_dq_o,
    input  wire logic              fl_dq_drive_n,
    input  wire logic              fl_ce_n,
    input  wire logic              fl_we_n,
    input  wire logic              fl_oe_n,
    output logic      [DATA_W-1:0] fl_dq_i
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] pd, wd, last, rv;
    logic [ADDR_W-1:0] wa, ers_a;
    logic              wr_q, rd_q, tog, armed, ers, eprep;
    int                busy;
    initial begin
        wr_q = 0; rd_q = 0; tog = 0; armed = 0; ers = 0; eprep = 0;
        busy = 0; last = 8'h00; pd = 8'h00;
        foreach (mem[i]) mem[i] = 8'hff;
    end
    // no sector is ever suspended, so bit 2 holds still
    assign rv = (busy != 0) ? {(ers ? 1'b0 : ~pd[7]), tog, 6'h00} : mem[fl_addr[3:0]];
    // released bus shows the inverse of the last byte, never a stale copy
    assign fl_dq_i = (!fl_ce_n && !fl_oe_n) ? rv : ~last;
    always @(posedge clk_sys) begin
        wr_q <= !fl_ce_n && !fl_we_n;
        rd_q <= !fl_ce_n && !fl_oe_n;
        if (!fl_ce_n && !fl_we_n) begin
            wa <= fl_addr;
            wd <= fl_dq_drive_n ? ~fl_dq_o : fl_dq_o;  // undriven data is garbage
        end
        if (wr_q && !(!fl_ce_n && !fl_we_n)) begin
            if (armed) begin
                mem[wa[3:0]] <= wd;
                pd <= wd;
                ers <= 0;
                busy <= 3;
                armed <= 0;
            end else if (eprep && (wd == 8'h30 || wd == 8'h10)) begin
                // zero fill first; erased bytes appear once the last busy read ends
                foreach (mem[i]) mem[i] <= 8'h00;
                ers_a <= wa;
                ers <= 1;
                busy <= 3;
                eprep <= 0;
            end
            if (wd == 8'ha0) armed <= 1;
            if (wd == 8'h80) eprep <= 1;
        end
        // toggle per read, done after a few reads
        if (!fl_ce_n && !fl_oe_n) last <= rv;
        if (rd_q && !(!fl_ce_n && !fl_oe_n)) begin
            tog <= ~tog;
            if (busy != 0 && !stuck) busy <= busy - 1;
            if (busy == 1 && ers && !stuck) foreach (mem[i]) mem[i] <= 8'hff;
        end
    end
endmodule

// ==== test/testbench.sv ====
// self-checking bench: controller against the behavioural flash
// assumes short timeout parameters so the run stays brief
`timescale 1ns/1ps
module testbench;
    import fpes_pkg::*;
    typedef struct packed {
        fpes_op_e op; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d;
        logic byp, cew, tgl, pce, chk; logic [DATA_W-1:0] exp;
    } fpes_row_s;
    logic clk_sys, rst, cmd_valid, cmd_ready, cmd_bypass, cmd_ce_write;
    logic cmd_poll_toggle, cmd_poll_by_ce, rsp_valid, rsp_timeout;
    logic fl_dq_drive_n, fl_ce_n, fl_we_n, fl_oe_n, stuck, got_tmo;
    fpes_op_e          cmd_op;
    logic [ADDR_W-1:0] cmd_addr, fl_addr;
    logic [DATA_W-1:0] cmd_data, rsp_data, fl_dq_o, fl_dq_i, got;
    int                mismatches, n_checks;
    fpes_row_s         rows [7];
    fpes_flash_ctrl #(.PROG_TMO(36'h0_0000_00c8), .SECT_TMO(36'h0_0000_0190),
        .CHIP_TMO(36'h0_0000_0190)) uut (.clk_sys, .rst, .cmd_valid, .cmd_ready,
        .cmd_op, .cmd_addr, .cmd_data, .cmd_bypass, .cmd_ce_write, .cmd_poll_toggle,
        .cmd_poll_by_ce, .rsp_valid, .rsp_timeout, .rsp_data, .fl_addr, .fl_dq_o,
        .fl_dq_drive_n, .fl_dq_i, .fl_ce_n, .fl_we_n, .fl_oe_n);
    fpes_flash_model u_flash (.clk_sys, .stuck, .fl_addr, .fl_dq_o, .fl_dq_drive_n,
        .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_dq_i);
    initial begin
        clk_sys = 0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [ADDR_W-1:0] g, input logic [ADDR_W-1:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one command, then wait a bounded time for its response pulse
    task automatic run(input fpes_row_s r);
        int n;
        cmd_valid <= 1; cmd_op <= r.op; cmd_addr <= r.a; cmd_data <= r.d;
        cmd_bypass <= r.byp; cmd_ce_write <= r.cew;
        cmd_poll_toggle <= r.tgl; cmd_poll_by_ce <= r.pce;
        @(posedge clk_sys);
        @(posedge clk_sys);
        cmd_valid <= 0;
        for (n = 0; n < 8000 && rsp_valid !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        got = rsp_data;
        got_tmo = rsp_timeout;
        chk(17'(rsp_valid), 17'h0_0001);
        if (r.chk) chk(17'({got_tmo, got}), 17'({1'b0, r.exp}));
        @(posedge clk_sys);
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys);
        mismatches++;
        results();
    end
    initial begin
        rst = 1; cmd_valid = 0; cmd_op = OP_READ; cmd_addr = 0; cmd_data = 0; stuck = 0;
        cmd_bypass = 0; cmd_ce_write = 0; cmd_poll_toggle = 0; cmd_poll_by_ce = 0;
        mismatches = 0; n_checks = 0;
        rows[0] = {OP_PROG, 17'h0_0010, 8'h5a, 5'b00001, 8'h5a};
        rows[1] = {OP_BYP_ENTER, 17'h0_0000, 8'h00, 5'b00000, 8'h00};
        rows[2] = {OP_PROG, 17'h0_0011, 8'ha5, 5'b11111, 8'ha5};
        rows[3] = {OP_BYP_EXIT, 17'h0_0000, 8'h00, 5'b00000, 8'h00};
        rows[4] = {OP_READ, 17'h0_0010, 8'h00, 5'b00011, 8'h5a};
        rows[5] = {OP_SECT_ERASE, 17'h0_4000, 8'h00, 5'b01101, 8'hff};
        rows[6] = {OP_CHIP_ERASE, 17'h0_0011, 8'h00, 5'b00001, 8'hff};
        repeat (6) @(posedge clk_sys);
        rst <= 0;
        #1;
        chk(17'({cmd_ready, fl_ce_n, fl_we_n, fl_oe_n}), 17'h0_000f);
        @(posedge clk_sys);
        foreach (rows[i]) begin
            run(rows[i]);
            if (rows[i].op == OP_SECT_ERASE) chk(u_flash.ers_a, rows[i].a);
        end
        // stuck flash must end in a timeout response carrying the status byte
        stuck <= 1;
        rows[0].chk = 1'b0;
        run(rows[0]);
        chk(17'(got_tmo), 17'h0_0001);
        chk(17'(got[7]), 17'(!rows[0].d[7]));
        chk(17'(got[2]), 17'h0_0000);
        results();
    end
endmodule
